/* File: rtl/i2cap_addr_poll.sv */
/*
  Address phase of a scripted I2C controller with acknowledge polling.
  Command side on clk; bit engine on linkClk. Assumes the script has already put a
  start or repeated start on the bus and holds SCL low when an address command arrives.
*/
`timescale 1ns/1ps
module i2cap_addr_poll
  import i2cap_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic linkClk,
  input wire logic cmdValid,
  input wire logic cmdRead,
  input wire logic [6:0] cmdAddr,
  input wire logic cmdRestart,
  input wire logic setTimeout,
  input wire logic [TO_W-1:0] timeoutMs,
  input wire logic scriptEnd,
  output logic cmdBusy,
  output logic cmdDone,
  output logic cmdAck,
  output logic cmdNackErr,
  output logic scriptAbort,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOeN
);

  i2cap_sys_type sysState;
  logic [TO_W-1:0] timeoutReg;
  logic [CNT_W-1:0] cycleCnt;
  logic [TO_W-1:0] msCount;
  logic reqToggle, reqStart, reqRestart;
  logic [7:0] reqByte;
  logic doneSync, doneSeen, doneEvt, expired;

  i2cap_lnk_type lnkState;
  logic [1:0] phase;
  logic [2:0] bitCnt;
  logic [7:0] shiftReg;
  logic doneToggle, ackRes, reqSeen, reqEvt, stall;
  logic [2:0] lnkSync;

  // ---------------- System domain ----------------
  i2cap_sync #(.W(1), .INIT(1'b0)) u_doneSync (
    .clk(clk),
    .nrst(nrst),
    .din(doneToggle),
    .dout(doneSync)
  );

  assign doneEvt = doneSync ^ doneSeen;
  assign expired = msCount >= timeoutReg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      timeoutReg <= TIMEOUT_DEFAULT;
    else if (scriptEnd)
      timeoutReg <= TIMEOUT_DEFAULT;
    else if (setTimeout)
      timeoutReg <= timeoutMs;
  end

  // Elapsed time counts from the first attempt; whole milliseconds only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cycleCnt <= '0;
      msCount <= '0;
    end
    else if (sysState == SYS_IDLE)
    begin
      cycleCnt <= '0;
      msCount <= '0;
    end
    else if (cycleCnt == CNT_W'(MS_CYCLES - 1))
    begin
      cycleCnt <= '0;
      if (!(&msCount))
        msCount <= msCount + 16'h0001;
    end
    else
      cycleCnt <= cycleCnt + 17'h00001;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sysState <= SYS_IDLE;
      doneSeen <= 1'b0;
      reqToggle <= 1'b0;
      reqStart <= 1'b0;
      reqRestart <= 1'b0;
      reqByte <= 8'h00;
      cmdBusy <= 1'b0;
      cmdDone <= 1'b0;
      cmdAck <= 1'b0;
      cmdNackErr <= 1'b0;
      scriptAbort <= 1'b0;
    end
    else
    begin
      cmdDone <= 1'b0;
      scriptAbort <= 1'b0;
      case (sysState)
        SYS_IDLE:
        begin
          if (cmdValid)
          begin
            reqByte <= {cmdAddr, cmdRead ? DIR_READ : DIR_WRITE};
            reqStart <= 1'b0;
            reqRestart <= cmdRestart;
            reqToggle <= ~reqToggle;
            cmdBusy <= 1'b1;
            cmdAck <= 1'b0;
            cmdNackErr <= 1'b0;
            sysState <= SYS_WAIT;
          end
        end
        SYS_WAIT:
        begin
          if (doneEvt)
          begin
            doneSeen <= doneSync;
            if (ackRes || timeoutReg == TIMEOUT_DEFAULT || expired)
            begin
              // Zero timeout takes the first answer as final, without abort
              cmdAck <= ackRes;
              cmdNackErr <= !ackRes;
              scriptAbort <= !ackRes && timeoutReg != TIMEOUT_DEFAULT;
              cmdDone <= 1'b1;
              cmdBusy <= 1'b0;
              sysState <= SYS_IDLE;
            end
            else
            begin
              reqStart <= 1'b1;
              reqToggle <= ~reqToggle;
            end
          end
        end
        default:
          sysState <= SYS_IDLE;
      endcase
    end
  end

  // ---------------- Link domain ----------------
  // Request fields stay stable from the toggle until the done toggle returns
  i2cap_sync #(.W(3), .INIT(3'b110)) u_lnkSync (
    .clk(linkClk),
    .nrst(nrst),
    .din({sdaIn, sclIn, reqToggle}),
    .dout(lnkSync)
  );

  assign reqEvt = lnkSync[0] ^ reqSeen;
  // Stretching: the high phase waits until SCL is seen high
  assign stall = phase == PH_HIGH1 && sclOeN && !lnkSync[1];

  always_ff @(posedge linkClk or negedge nrst)
  begin
    if (!nrst)
    begin
      sdaOut <= 1'b0;
      sclOut <= 1'b0;
    end
    else
    begin
      sdaOut <= 1'b0;
      sclOut <= 1'b0;
    end
  end

  always_ff @(posedge linkClk or negedge nrst)
  begin
    if (!nrst)
    begin
      lnkState <= LNK_IDLE;
      phase <= PH_LOW0;
      bitCnt <= 3'h0;
      shiftReg <= 8'h00;
      reqSeen <= 1'b0;
      doneToggle <= 1'b0;
      ackRes <= 1'b0;
      sdaOeN <= 1'b1;
      sclOeN <= 1'b1;
    end
    else
    begin
      if (lnkState != LNK_IDLE && !stall)
        phase <= phase + 2'h1;
      case (lnkState)
        LNK_IDLE:
        begin
          phase <= PH_LOW0;
          bitCnt <= 3'h0;
          if (reqEvt)
          begin
            reqSeen <= lnkSync[0];
            shiftReg <= reqByte;
            if (!reqStart)
              lnkState <= LNK_BIT;
            else if (reqRestart)
              lnkState <= LNK_START;
            else
              lnkState <= LNK_STOP;
          end
        end
        LNK_STOP:
        begin
          // Plain start retry frees the bus first, then starts anew
          case (phase)
            PH_LOW0: sclOeN <= 1'b0;
            PH_LOW1: sdaOeN <= 1'b0;
            PH_HIGH0: sclOeN <= 1'b1;
            PH_HIGH1:
            begin
              if (!stall)
              begin
                sdaOeN <= 1'b1;
                lnkState <= LNK_START;
              end
            end
            default: ;
          endcase
        end
        LNK_START:
        begin
          case (phase)
            PH_LOW0: sdaOeN <= 1'b1;
            PH_LOW1: sclOeN <= 1'b1;
            PH_HIGH0: sdaOeN <= 1'b0;
            PH_HIGH1:
            begin
              if (!stall)
              begin
                sclOeN <= 1'b0;
                lnkState <= LNK_BIT;
              end
            end
            default: ;
          endcase
        end
        LNK_BIT:
        begin
          case (phase)
            // Data moves a phase after SCL falls, so no SDA edge can pass for a start or stop
            PH_LOW0: sclOeN <= 1'b0;
            PH_LOW1: sdaOeN <= shiftReg[7];
            PH_HIGH0: sclOeN <= 1'b1;
            PH_HIGH1:
            begin
              if (!stall)
              begin
                shiftReg <= {shiftReg[6:0], 1'b0};
                bitCnt <= bitCnt + 3'h1;
                if (bitCnt == BIT_LAST)
                  lnkState <= LNK_ACK;
              end
            end
            default: ;
          endcase
        end
        LNK_ACK:
        begin
          case (phase)
            PH_LOW0: sclOeN <= 1'b0;
            PH_LOW1: sdaOeN <= 1'b1;
            PH_HIGH0: sclOeN <= 1'b1;
            PH_HIGH1:
            begin
              if (!stall)
              begin
                ackRes <= !lnkSync[2];
                doneToggle <= ~doneToggle;
                sclOeN <= 1'b0;
                lnkState <= LNK_IDLE;
              end
            end
            default: ;
          endcase
        end
        default:
          lnkState <= LNK_IDLE;
      endcase
    end
  end

  // ---------------- Assertions and covers ----------------
  property p_readDir;
    @(posedge clk) disable iff (!nrst)
    sysState == SYS_IDLE && cmdValid && cmdRead |=> reqByte[0] == DIR_READ && reqByte[7:1] == $past(cmdAddr);
  endproperty
  a_readDir: assert property (p_readDir) else $error("read address byte wrong");

  property p_writeDir;
    @(posedge clk) disable iff (!nrst)
    sysState == SYS_IDLE && cmdValid && !cmdRead |=> reqByte == {$past(cmdAddr), DIR_WRITE};
  endproperty
  a_writeDir: assert property (p_writeDir) else $error("write address byte wrong");

  property p_zeroFinal;
    @(posedge clk) disable iff (!nrst)
    sysState == SYS_WAIT && doneEvt && !ackRes && timeoutReg == TIMEOUT_DEFAULT
      |=> cmdDone && cmdNackErr && !scriptAbort && sysState == SYS_IDLE;
  endproperty
  a_zeroFinal: assert property (p_zeroFinal) else $error("zero timeout did not finish");

  property p_retry;
    @(posedge clk) disable iff (!nrst)
    sysState == SYS_WAIT && doneEvt && !ackRes && timeoutReg != TIMEOUT_DEFAULT && !expired
      |=> !cmdDone && reqStart && reqToggle != $past(reqToggle) && $stable(reqByte);
  endproperty
  a_retry: assert property (p_retry) else $error("nack did not retry");

  property p_abort;
    @(posedge clk) disable iff (!nrst)
    sysState == SYS_WAIT && doneEvt && !ackRes && timeoutReg != TIMEOUT_DEFAULT && expired
      |=> cmdDone && cmdNackErr && scriptAbort ##1 !scriptAbort;
  endproperty
  a_abort: assert property (p_abort) else $error("timeout did not abort");

  property p_scriptEnd;
    @(posedge clk) disable iff (!nrst)
    scriptEnd |=> timeoutReg == TIMEOUT_DEFAULT;
  endproperty
  a_scriptEnd: assert property (p_scriptEnd) else $error("timeout not cleared");

  property p_msTick;
    @(posedge clk) disable iff (!nrst)
    sysState == SYS_WAIT && cycleCnt == CNT_W'(MS_CYCLES - 1) && !(&msCount)
      |=> msCount == $past(msCount) + 16'h0001 && cycleCnt == '0;
  endproperty
  a_msTick: assert property (p_msTick) else $error("millisecond count wrong");

  property p_ackRelease;
    @(posedge linkClk) disable iff (!nrst)
    lnkState == LNK_ACK && (phase == PH_HIGH0 || phase == PH_HIGH1) |-> sdaOeN;
  endproperty
  a_ackRelease: assert property (p_ackRelease) else $error("data held during acknowledge");

  property p_dataStable;
    @(posedge linkClk) disable iff (!nrst)
    lnkState == LNK_BIT && (phase == PH_HIGH0 || phase == PH_HIGH1) |=> $stable(sdaOeN);
  endproperty
  a_dataStable: assert property (p_dataStable) else $error("data moved while clock high");

  c_firstAck: cover property (@(posedge clk) disable iff (!nrst) cmdDone && cmdAck);
  c_retried: cover property (@(posedge clk) disable iff (!nrst) reqStart && cmdDone && cmdAck);
  c_aborted: cover property (@(posedge clk) disable iff (!nrst) scriptAbort);

endmodule

/* File: rtl/i2cap_pkg.sv */
/*
  Shared constants and types for the I2C address phase with acknowledge polling.
  Assumes a 125 MHz system clock and a separate free-running link clock for the bit engine.
*/
package i2cap_pkg;

  // System clock and millisecond unit of the poll timeout
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_PERIOD_NS = 1_000_000;
  localparam int MS_CYCLES_DEF = MS_PERIOD_NS / CLK_PERIOD_NS;

  localparam int TO_W = 16;
  localparam int CNT_W = 17;
  localparam logic [TO_W-1:0] TIMEOUT_DEFAULT = 16'h0000;

  // Direction bit placed in bit 0 of the address byte
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  // Bit engine: four link clock phases per bus bit, eight bits then acknowledge
  localparam logic [1:0] PH_LOW0 = 2'h0;
  localparam logic [1:0] PH_LOW1 = 2'h1;
  localparam logic [1:0] PH_HIGH0 = 2'h2;
  localparam logic [1:0] PH_HIGH1 = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [1:0] {
    SYS_IDLE = 2'b01,
    SYS_WAIT = 2'b10
  } i2cap_sys_type;

  typedef enum logic [4:0] {
    LNK_IDLE = 5'b00001,
    LNK_STOP = 5'b00010,
    LNK_START = 5'b00100,
    LNK_BIT = 5'b01000,
    LNK_ACK = 5'b10000
  } i2cap_lnk_type;

endpackage

/* File: rtl/i2cap_sync.sv */
/*
  Two flip-flop synchroniser for a group of independent levels.
  Assumes the inputs are levels or toggles from another clock domain or from pins.
*/
`timescale 1ns/1ps
module i2cap_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta <= INIT;
      dout <= INIT;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

/* File: verif/i2cap_target_model.sv */
/*
  Behavioural I2C target that receives the address byte and answers the acknowledge bit.
  Assumes the bench resolves both open-drain wires with pull-ups and feeds them back here.
*/
`timescale 1ns/1ps
module i2cap_target_model (
  input wire logic scl,
  input wire logic sda,
  output logic sdaPullN,
  output logic sclPullN
);
  int nackLeft = 0;
  int stretchNs = 0;
  int starts = 0;
  int stops = 0;
  int cnt = 0;
  logic [7:0] sh;
  logic [7:0] rx[$];
  initial
  begin
    sdaPullN = 1'h1;
    sclPullN = 1'h1;
  end
  always @(negedge sda)
    if (scl === 1'h1)
    begin
      starts++;
      cnt = 0;
    end
  always @(posedge sda)
    if (scl === 1'h1)
      stops++;
  always @(posedge scl)
    if (cnt < 8)
    begin
      sh = {sh[6:0], sda};
      cnt++;
      if (cnt == 8)
        rx.push_back(sh);
    end
  // Answer is held for the whole ninth clock; a refusal simply leaves the pull-up in charge
  always @(negedge scl)
  begin
    if (cnt == 8)
    begin
      sdaPullN = (nackLeft != 0);
      if (nackLeft != 0)
        nackLeft--;
      cnt = 9;
    end
    else if (cnt == 9)
    begin
      sdaPullN = 1'h1;
      cnt = 10;
    end
    if (stretchNs > 0)
    begin
      sclPullN = 1'h0;
      #(stretchNs) sclPullN = 1'h1;
    end
  end
endmodule

/* File: verif/i2c_address_phase_ack_poll_tb.sv */
/*
  Self-checking bench for the address phase with acknowledge polling.
  Assumes the target model stands on the wires and that the bench itself plays the start that precedes a command.
*/
`timescale 1ns/1ps
module i2c_address_phase_ack_poll_tb;
  import i2cap_pkg::*;
  localparam int MSC = 400;
  localparam int LIM = 20000;
  logic clk, linkClk, nrst, cmdValid, cmdRead, cmdRestart, setTimeout, scriptEnd;
  logic [6:0] cmdAddr;
  logic [TO_W-1:0] timeoutMs;
  logic cmdBusy, cmdDone, cmdAck, cmdNackErr, scriptAbort, sdaOut, sdaOeN, sclOut, sclOeN;
  logic bSda = 1'h1;
  logic bScl = 1'h1;
  wire logic sdaPullN;
  wire logic sclPullN;
  wire logic scl;
  wire logic sda;
  int nErrors = 0;
  int checked = 0;
  int seed = 32'hC81A;
  int nkT[7] = '{0, 1, 2, 2, 1000, 1, 1};
  int toT[7] = '{0, 0, 100, 100, 8, 100, 100};
  bit esT[7] = '{0, 0, 0, 0, 0, 1, 0};
  bit rsT[7] = '{0, 1, 0, 1, 1, 0, 0};
  int stT[7] = '{0, 0, 0, 0, 0, 0, 400};
  assign scl = (sclOeN ? 1'h1 : sclOut) & sclPullN & bScl;
  assign sda = (sdaOeN ? 1'h1 : sdaOut) & sdaPullN & bSda;
  i2cap_addr_poll #(.MS_CYCLES(MSC)) i2cap_addr_poll_inst (.clk(clk), .nrst(nrst), .linkClk(linkClk),
    .cmdValid(cmdValid), .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdRestart(cmdRestart),
    .setTimeout(setTimeout), .timeoutMs(timeoutMs), .scriptEnd(scriptEnd), .cmdBusy(cmdBusy),
    .cmdDone(cmdDone), .cmdAck(cmdAck), .cmdNackErr(cmdNackErr), .scriptAbort(scriptAbort),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .sclIn(scl), .sclOut(sclOut), .sclOeN(sclOeN));
  i2cap_target_model i2cap_target_model_inst (.scl(scl), .sda(sda), .sdaPullN(sdaPullN), .sclPullN(sclPullN));
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    linkClk = 1'h0;
    #37;
    forever #80 linkClk = ~linkClk;
  end
  task automatic closeOut;
    $display("errors %0d checks %0d", nErrors, checked);
    if (nErrors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'h1)
    begin
      nErrors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // Held over slow-clock edges so the link side sees the reset too
  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'h0;
    repeat (8) @(posedge linkClk);
    @(posedge clk);
    nrst <= 1'h1;
    repeat (64) @(posedge clk);
  endtask
  task automatic set_to(input int t, input bit es);
    @(posedge clk);
    setTimeout <= 1'h1;
    timeoutMs <= TO_W'(t);
    scriptEnd <= es;
    @(posedge clk);
    setTimeout <= 1'h0;
    scriptEnd <= 1'h0;
  endtask
  // The script's own start, left with SCL low as the command expects
  task automatic bus_start;
    #101 bSda = 1'h0;
    #203 bScl = 1'h0;
    #205 bSda = 1'h1;
  endtask
  task automatic run(input logic rd, input logic [6:0] a, input logic rs, output int n, output logic ab);
    n = 0;
    @(posedge clk);
    cmdValid <= 1'h1;
    cmdRead <= rd;
    cmdAddr <= a;
    cmdRestart <= rs;
    @(posedge clk);
    cmdValid <= 1'h0;
    #1;
    while (cmdDone !== 1'h1 && n < LIM)
    begin
      @(posedge clk);
      cmdValid <= (n == 30);
      cmdAddr <= (n == 30) ? ~a : a;
      #1;
      n++;
      if (sclOeN === 1'h0)
        bScl = 1'h1;
    end
    ab = scriptAbort;
    chk(n < LIM && cmdBusy === 1'h0, "no completion");
  endtask
  task automatic scen(input int nk, input int to, input bit es, input bit rs, input int st);
    logic rd;
    logic [6:0] a;
    logic ab;
    int cyc;
    int tries;
    int teff;
    bit expAb;
    bit expAck;
    do_reset;
    set_to(to, es);
    rd = 1'($random(seed));
    a = 7'($random(seed));
    i2cap_target_model_inst.nackLeft = nk;
    i2cap_target_model_inst.stretchNs = st;
    bus_start;
    i2cap_target_model_inst.starts = 0;
    i2cap_target_model_inst.stops = 0;
    i2cap_target_model_inst.rx.delete();
    run(rd, a, rs, cyc, ab);
    teff = es ? 0 : to;
    expAb = (teff != 0) && (nk > 100);
    expAck = (nk == 0) || (teff != 0 && !expAb);
    tries = i2cap_target_model_inst.rx.size();
    chk(cmdAck === expAck && cmdNackErr === !expAck, "ack result");
    chk(ab === expAb, "abort flag");
    chk(teff == 0 ? tries == 1 : (expAb ? tries >= 2 : tries == nk + 1), "attempts");
    foreach (i2cap_target_model_inst.rx[i])
      chk(i2cap_target_model_inst.rx[i] === {a, rd}, "address byte");
    chk(i2cap_target_model_inst.starts == tries - 1, "start count");
    chk(i2cap_target_model_inst.stops == (rs ? 0 : tries - 1), "stop count");
    chk(!expAb || cyc >= to * MSC, "timeout span");
  endtask
  initial
  begin
    nrst = 1'h0;
    cmdValid = 1'h0;
    cmdRead = 1'h0;
    cmdAddr = 7'h00;
    cmdRestart = 1'h0;
    setTimeout = 1'h0;
    timeoutMs = 16'h0000;
    scriptEnd = 1'h0;
    for (int i = 0; i < 7; i++)
      scen(nkT[i], toT[i], esT[i], rsT[i], stT[i]);
    closeOut;
  end
  initial
  begin
    #600000;
    nErrors++;
    $display("BAD %0t watchdog expired", $time);
    closeOut;
  end
endmodule
